// >>> rio_pkg.sv
// shared constants and types for the remote I/O mode control block
package rio_pkg;
  // clock rate and long timings, figures in their own units
  localparam int unsigned CLK_KHZ = 25000;
  localparam int unsigned RESTART_MS = 3000;
  localparam int unsigned RESTART_CYC = RESTART_MS * CLK_KHZ;
  localparam int unsigned LINK_TMO_MS = 100;
  localparam logic [31:0] LINK_TMO_RST = 32'(LINK_TMO_MS * CLK_KHZ);
  // register byte offsets
  localparam logic [7:0] OFS_CFG = 8'h00;
  localparam logic [7:0] OFS_KEY = 8'h04;
  localparam logic [7:0] OFS_STAT = 8'h08;
  localparam logic [7:0] OFS_TMO = 8'h0C;
  localparam logic [7:0] OFS_CMD = 8'h10;
  localparam logic [7:0] OFS_PAR_L = 8'h14;
  localparam logic [7:0] OFS_PAR_R = 8'h18;
  localparam logic [7:0] OFS_TEL_L0 = 8'h1C;
  localparam logic [7:0] OFS_TEL_L1 = 8'h20;
  localparam logic [7:0] OFS_TEL_R0 = 8'h24;
  localparam logic [7:0] OFS_TEL_R1 = 8'h28;
  localparam logic [7:0] OFS_ZONE = 8'h2C;
  // reconfiguration key that alone leaves remote mode
  localparam logic [31:0] RECONF_KEY = 32'h5EC0_0F1A;
  // configuration fields
  localparam int CFG_MODE = 0;
  localparam int CFG_NCLR = 1;
  localparam int CFG_ALLOFF = 2;
  // command fields
  localparam int CMD_RUN = 0;
  localparam int CMD_DMODE = 2;
  localparam int CMD_DOUT = 4;
  localparam int CMD_STOP = 6;
  localparam int CMD_AUX = 8;
  localparam int CMD_CLR = 12;
  // motor parameter fields
  localparam int PAR_SPD = 0;
  localparam int PAR_ACC = 16;
  localparam int PAR_DEC = 24;
  localparam int PAR_BRK = 31;
  // status fields
  localparam int STA_MODE = 0;
  localparam int STA_RST = 1;
  localparam int STA_LOST = 2;
  localparam int STA_FAULT = 3;
  localparam int STA_SENS = 8;
  // operating mode of the module
  typedef enum logic [1:0] {
    ST_ZONE = 2'b00,
    ST_RESTART = 2'b01,
    ST_REMOTE = 2'b10
  } mode_state_t;
endpackage

// >>> motor_cmd_if.sv
// command and drive bundle between the control core and one motor port
`timescale 1ns/1ps
interface motor_cmd_if;
  logic run, dig_mode, dig_out, brake, clear_err, fault_in;
  logic [15:0] speed;
  logic [7:0] accel;
  logic [6:0] decel;
  logic drv_run, drv_dig_mode, drv_dig_out, drv_brake, fault;
  logic [15:0] drv_speed;
  logic [7:0] drv_accel;
  logic [6:0] drv_decel;
  modport ctrl (output run, dig_mode, dig_out, brake, clear_err, fault_in, speed, accel,
    decel, input drv_run, drv_dig_mode, drv_dig_out, drv_brake, fault, drv_speed,
    drv_accel, drv_decel);
  modport port (input run, dig_mode, dig_out, brake, clear_err, fault_in, speed, accel,
    decel, output drv_run, drv_dig_mode, drv_dig_out, drv_brake, fault, drv_speed,
    drv_accel, drv_decel);
endinterface

// >>> link_watchdog.sv
// controller link watchdog: declares loss when updates stop arriving
`timescale 1ns/1ps
module link_watchdog (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic enable,
  input wire logic kick,
  input wire logic [31:0] tmo,
  output logic lost,
  output logic lost_pulse
);
  logic [31:0] cnt; // cycles since last update
  logic expire;
  // a zero timeout disables detection
  assign expire = enable & ~kick & ~lost & (tmo != 32'h0000_0000) & (cnt >= tmo - 32'h1);
  // count idle cycles, raise loss once, drop it on the next update
  always_ff @(posedge clk)
  begin
    if (!rst_b | !enable | kick)
    begin
      cnt <= 32'h0000_0000;
      lost <= 1'b0;
      lost_pulse <= 1'b0;
    end
    else
    begin
      cnt <= lost ? cnt : cnt + 32'h1;
      lost <= lost | expire;
      lost_pulse <= expire;
    end
  end
  chk_loss_single_pulse: assert property (@(posedge clk) disable iff (!rst_b)
    lost_pulse && enable && !kick |=> !lost_pulse && lost)
    else $error("loss pulse not single");
  chk_kick_restores_link: assert property (@(posedge clk) disable iff (!rst_b)
    kick |=> !lost && cnt == 32'h0000_0000) else $error("update did not restore");
endmodule

// >>> motor_port.sv
// one motor port: gating of commanded drive, loss response, fault latch
`timescale 1ns/1ps
module motor_port (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic active,
  input wire logic link_lost,
  input wire logic all_off,
  input wire logic stop_all,
  motor_cmd_if.port m
);
  logic next_fault;
  logic gate_off;
  logic hold;
  // new fault wins over a clear in the same cycle
  assign next_fault = m.fault_in | (m.fault & ~m.clear_err);
  // everything off outside remote mode, on stop, or on loss with all-off
  assign gate_off = ~active | stop_all | (link_lost & all_off);
  assign hold = link_lost & ~all_off;
  // fatal fault latch
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      m.fault <= 1'b0;
    else
      m.fault <= next_fault;
  end
  // drive registers: off, frozen on loss, or following the controller
  always_ff @(posedge clk)
  begin
    if (!rst_b | gate_off)
    begin
      m.drv_run <= 1'b0;
      m.drv_dig_mode <= 1'b0;
      m.drv_dig_out <= 1'b0;
      m.drv_brake <= 1'b0;
      m.drv_speed <= 16'h0000;
      m.drv_accel <= 8'h00;
      m.drv_decel <= 7'h00;
    end
    else if (!hold)
    begin
      // a port in digital mode never runs its motor
      m.drv_run <= m.run & ~m.dig_mode & ~m.fault;
      m.drv_dig_mode <= m.dig_mode;
      m.drv_dig_out <= m.dig_out & m.dig_mode;
      m.drv_brake <= m.brake;
      m.drv_speed <= m.speed;
      m.drv_accel <= m.accel;
      m.drv_decel <= m.decel;
    end
  end
  chk_all_off_loss: assert property (@(posedge clk) disable iff (!rst_b)
    link_lost && all_off |=> !m.drv_run && !m.drv_dig_out) else $error("loss not off");
  chk_hold_on_loss: assert property (@(posedge clk) disable iff (!rst_b)
    active && !stop_all && hold |=> $stable(m.drv_run) && $stable(m.drv_speed))
    else $error("outputs moved during hold");
  chk_fault_clear: assert property (@(posedge clk) disable iff (!rst_b)
    m.fault && m.clear_err && !m.fault_in |=> !m.fault ##1 !m.drv_run || m.run)
    else $error("fault not cleared");
endmodule

// >>> remote_io_ctrl.sv
// remote I/O mode control: bus registers, mode entry, neighbour link, loss
//
// Design decisions made here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module remote_io_ctrl #(
  parameter int unsigned RESTART_CYCLES = rio_pkg::RESTART_CYC
) (
  input wire logic clk,
  input wire logic rst_b,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // persistent mode copy kept by nonvolatile storage
  input wire logic nv_mode_in,
  output logic nv_mode,
  output logic zone_auto_en,
  // sensor ports and aux outputs
  input wire logic [3:0] sens_in,
  output logic [1:0] aux_out,
  // motor drive, index 0 left, 1 right
  output logic [1:0] motor_run,
  output logic [1:0] motor_brake,
  output logic [1:0] port_dig_mode,
  output logic [1:0] port_dig_out,
  output logic [31:0] motor_speed,
  output logic [15:0] motor_accel,
  output logic [13:0] motor_decel,
  output logic [1:0] motor_fault,
  // motor fault inputs, one bit per motor, and telemetry, 16 bits per motor
  input wire logic [1:0] mot_fault_in,
  input wire logic [31:0] mot_freq,
  input wire logic [31:0] mot_cur,
  input wire logic [31:0] mot_temp,
  input wire logic [31:0] mot_err,
  // neighbour module status link
  input wire logic nbr_rx_valid,
  input wire logic [15:0] nbr_rx_data,
  output logic nbr_tx_valid,
  output logic [15:0] nbr_tx_data,
  output logic link_lost
);
  rio_pkg::mode_state_t state; // current mode
  rio_pkg::mode_state_t next_state;
  logic booted; // nonvolatile mode already reloaded
  logic [31:0] restart_cnt; // cycles left in restart
  logic cfg_nclr; // neighbour links cleared
  logic cfg_alloff; // all-off chosen for link loss
  logic [31:0] link_tmo; // loss timeout in cycles
  logic [1:0] cmd_run;
  logic [1:0] cmd_dmode;
  logic [1:0] cmd_dout;
  logic cmd_stop;
  logic [1:0] cmd_clr; // one-cycle clear pulses
  logic [31:0] mpar [2]; // per-motor speed, ramps and brake
  logic [15:0] zone_rx; // status received from neighbours
  logic [3:0] sens; // sampled sensor inputs
  logic ap_wr; // data phase of a write
  logic [7:0] ap_addr; // latched write address
  logic take; // address phase accepted
  logic remote;
  logic active;
  logic wr_cfg, wr_key, wr_tmo, wr_cmd, wr_par_l, wr_par_r, wr_zone;
  logic kick; // controller output update
  logic enter_req;
  logic exit_req;
  logic [31:0] rd_word;
  logic lost_pulse;
  logic [1:0] fault_w;

  // address phase decode and data phase write selects
  assign take = hsel & hready & htrans[1];
  assign wr_cfg = ap_wr & (ap_addr == rio_pkg::OFS_CFG);
  assign wr_key = ap_wr & (ap_addr == rio_pkg::OFS_KEY);
  assign wr_tmo = ap_wr & (ap_addr == rio_pkg::OFS_TMO);
  assign wr_cmd = ap_wr & (ap_addr == rio_pkg::OFS_CMD);
  assign wr_par_l = ap_wr & (ap_addr == rio_pkg::OFS_PAR_L);
  assign wr_par_r = ap_wr & (ap_addr == rio_pkg::OFS_PAR_R);
  assign wr_zone = ap_wr & (ap_addr == rio_pkg::OFS_ZONE);
  assign remote = (state == rio_pkg::ST_REMOTE);
  assign active = remote;
  // any write of commands or motor parameters counts as an update
  assign kick = remote & (wr_cmd | wr_par_l | wr_par_r);
  assign enter_req = wr_cfg & hwdata[rio_pkg::CFG_MODE];
  // only the reconfiguration key leaves remote mode
  assign exit_req = wr_key & (hwdata == rio_pkg::RECONF_KEY);

  // bus handshake: every transfer completes with no wait state, OKAY
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_wr <= 1'b0;
      ap_addr <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_wr <= take & hwrite;
      ap_addr <= haddr[7:0];
    end
  end

  // read data mux, unmapped offsets read as zero
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (haddr[7:0])
      rio_pkg::OFS_CFG:
      begin
        rd_word[rio_pkg::CFG_MODE] = remote | (state == rio_pkg::ST_RESTART);
        rd_word[rio_pkg::CFG_NCLR] = cfg_nclr;
        rd_word[rio_pkg::CFG_ALLOFF] = cfg_alloff;
      end
      rio_pkg::OFS_STAT:
      begin
        rd_word[rio_pkg::STA_MODE] = remote;
        rd_word[rio_pkg::STA_RST] = (state == rio_pkg::ST_RESTART);
        rd_word[rio_pkg::STA_LOST] = link_lost;
        rd_word[rio_pkg::STA_FAULT +: 2] = fault_w;
        rd_word[rio_pkg::STA_SENS +: 4] = sens;
      end
      rio_pkg::OFS_TMO: rd_word = link_tmo;
      rio_pkg::OFS_CMD:
      begin
        rd_word[rio_pkg::CMD_RUN +: 2] = cmd_run;
        rd_word[rio_pkg::CMD_DMODE +: 2] = cmd_dmode;
        rd_word[rio_pkg::CMD_DOUT +: 2] = cmd_dout;
        rd_word[rio_pkg::CMD_STOP] = cmd_stop;
        rd_word[rio_pkg::CMD_AUX +: 2] = aux_out;
      end
      rio_pkg::OFS_PAR_L: rd_word = mpar[0];
      rio_pkg::OFS_PAR_R: rd_word = mpar[1];
      // telemetry: frequency, current, temperature, error word
      rio_pkg::OFS_TEL_L0: rd_word = {mot_cur[15:0], mot_freq[15:0]};
      rio_pkg::OFS_TEL_L1: rd_word = {mot_err[15:0], mot_temp[15:0]};
      rio_pkg::OFS_TEL_R0: rd_word = {mot_cur[31:16], mot_freq[31:16]};
      rio_pkg::OFS_TEL_R1: rd_word = {mot_err[31:16], mot_temp[31:16]};
      rio_pkg::OFS_ZONE: rd_word = {zone_rx, nbr_tx_data};
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // read data registered at the address phase, stands in the data phase
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      hrdata <= 32'h0000_0000;
    else if (take & ~hwrite)
      hrdata <= rd_word;
  end

  // mode sequencing
  always_comb
  begin
    next_state = state;
    case (state)
      rio_pkg::ST_ZONE:
      begin
        // nonvolatile copy brings the module back in remote mode after reset
        if (!booted & nv_mode_in)
          next_state = rio_pkg::ST_REMOTE;
        else if (enter_req)
          next_state = rio_pkg::ST_RESTART;
      end
      rio_pkg::ST_RESTART:
      begin
        if (restart_cnt == 32'h0000_0000)
          next_state = rio_pkg::ST_REMOTE;
      end
      rio_pkg::ST_REMOTE:
      begin
        if (exit_req)
          next_state = rio_pkg::ST_ZONE;
      end
      default: next_state = rio_pkg::ST_ZONE;
    endcase
  end

  // mode state, restart timer and persistent copy
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= rio_pkg::ST_ZONE;
      booted <= 1'b0;
      restart_cnt <= 32'h0000_0000;
      nv_mode <= 1'b0;
      zone_auto_en <= 1'b0;
    end
    else
    begin
      state <= next_state;
      booted <= 1'b1;
      // restart lasts the full count; busy time is several seconds
      if (state == rio_pkg::ST_ZONE)
        restart_cnt <= 32'(RESTART_CYCLES - 1);
      else if (restart_cnt != 32'h0000_0000)
        restart_cnt <= restart_cnt - 32'h1;
      nv_mode <= (next_state != rio_pkg::ST_ZONE);
      // automatic accumulation runs only in zone mode, held off until booted
      zone_auto_en <= booted & (next_state == rio_pkg::ST_ZONE);
    end
  end

  // link options are taken only when the mode change is applied; the timeout on any write
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      cfg_nclr <= 1'b0;
      cfg_alloff <= 1'b0;
      link_tmo <= rio_pkg::LINK_TMO_RST;
    end
    else
    begin
      if (enter_req & (state == rio_pkg::ST_ZONE))
      begin
        cfg_nclr <= hwdata[rio_pkg::CFG_NCLR];
        cfg_alloff <= hwdata[rio_pkg::CFG_ALLOFF];
      end
      if (wr_tmo)
        link_tmo <= hwdata;
    end
  end

  // controller commands, held at zero outside remote mode
  always_ff @(posedge clk)
  begin
    if (!rst_b | !remote)
    begin
      cmd_run <= 2'b00;
      cmd_dmode <= 2'b00;
      cmd_dout <= 2'b00;
      cmd_stop <= 1'b0;
      cmd_clr <= 2'b00;
      aux_out <= 2'b00;
      mpar[0] <= 32'h0000_0000;
      mpar[1] <= 32'h0000_0000;
    end
    else
    begin
      // clear pulses last one cycle after the write
      cmd_clr <= wr_cmd ? hwdata[rio_pkg::CMD_CLR +: 2] : 2'b00;
      if (wr_cmd)
      begin
        cmd_run <= hwdata[rio_pkg::CMD_RUN +: 2];
        cmd_dmode <= hwdata[rio_pkg::CMD_DMODE +: 2];
        cmd_dout <= hwdata[rio_pkg::CMD_DOUT +: 2];
        cmd_stop <= hwdata[rio_pkg::CMD_STOP];
      end
      // aux outputs obey the same loss response as the motors
      if (link_lost & cfg_alloff)
        aux_out <= 2'b00;
      else if (wr_cmd & ~link_lost)
        aux_out <= hwdata[rio_pkg::CMD_AUX +: 2];
      if (wr_par_l)
        mpar[0] <= hwdata;
      if (wr_par_r)
        mpar[1] <= hwdata;
    end
  end

  // neighbour link: forward zone status and take in neighbour status
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      nbr_tx_valid <= 1'b0;
      nbr_tx_data <= 16'h0000;
      zone_rx <= 16'h0000;
      sens <= 4'h0;
    end
    else
    begin
      sens <= sens_in;
      nbr_tx_valid <= wr_zone & remote & ~cfg_nclr;
      if (wr_zone & remote)
        nbr_tx_data <= hwdata[15:0];
      if (nbr_rx_valid & ~cfg_nclr)
        zone_rx <= nbr_rx_data;
    end
  end

  // controller link watchdog
  link_watchdog u_wdog (
    .clk(clk),
    .rst_b(rst_b),
    .enable(remote),
    .kick(kick),
    .tmo(link_tmo),
    .lost(link_lost),
    .lost_pulse(lost_pulse)
  );

  // one motor port per side
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : gen_motor
      motor_cmd_if mi ();
      assign mi.run = cmd_run[g];
      assign mi.dig_mode = cmd_dmode[g];
      assign mi.dig_out = cmd_dout[g];
      assign mi.clear_err = cmd_clr[g];
      assign mi.fault_in = mot_fault_in[g];
      assign mi.speed = mpar[g][rio_pkg::PAR_SPD +: 16];
      assign mi.accel = mpar[g][rio_pkg::PAR_ACC +: 8];
      assign mi.decel = mpar[g][rio_pkg::PAR_DEC +: 7];
      assign mi.brake = mpar[g][rio_pkg::PAR_BRK];
      motor_port u_port (
        .clk(clk),
        .rst_b(rst_b),
        .active(active),
        .link_lost(link_lost),
        .all_off(cfg_alloff),
        .stop_all(cmd_stop),
        .m(mi)
      );
      assign motor_run[g] = mi.drv_run;
      assign motor_brake[g] = mi.drv_brake;
      assign port_dig_mode[g] = mi.drv_dig_mode;
      assign port_dig_out[g] = mi.drv_dig_out;
      assign motor_speed[g*16 +: 16] = mi.drv_speed;
      assign motor_accel[g*8 +: 8] = mi.drv_accel;
      assign motor_decel[g*7 +: 7] = mi.drv_decel;
      assign motor_fault[g] = mi.fault;
      assign fault_w[g] = mi.fault;
    end
  endgenerate

  chk_entry_restarts: assert property (@(posedge clk) disable iff (!rst_b)
    state == rio_pkg::ST_ZONE && booted && enter_req |=> state == rio_pkg::ST_RESTART
    ##1 !remote) else $error("entry did not restart");
  chk_stay_remote: assert property (@(posedge clk) disable iff (!rst_b)
    remote && !exit_req |=> remote) else $error("left remote mode");
  chk_no_auto_motion: assert property (@(posedge clk) disable iff (!rst_b)
    !remote |=> cmd_run == 2'b00 ##1 motor_run == 2'b00) else $error("motion off mode");
  chk_nbr_forward: assert property (@(posedge clk) disable iff (!rst_b)
    wr_zone && remote && !cfg_nclr |=> nbr_tx_valid && nbr_tx_data == $past(hwdata[15:0]))
    else $error("zone status not forwarded");
  chk_nbr_inhibit: assert property (@(posedge clk) disable iff (!rst_b)
    cfg_nclr |=> !nbr_tx_valid) else $error("forwarded with links cleared");
  chk_sensor_report: assert property (@(posedge clk) disable iff (!rst_b)
    take && !hwrite && haddr[7:0] == rio_pkg::OFS_STAT
    |=> hrdata[rio_pkg::STA_SENS +: 4] == $past(sens)) else $error("sensor read wrong");
  chk_stop_all: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_stop |=> motor_run == 2'b00) else $error("stop did not halt motors");
endmodule

// >>> nbr_model.sv
// neighbour module and motor drive stand-in facing the control block
`timescale 1ns/1ps
module nbr_model #(
  parameter logic [15:0] RX_WORD = 16'hA5C3
) (
  input wire logic clk,
  input wire logic flt_go,
  input wire logic rx_go,
  output logic [1:0] mot_fault_in,
  output logic nbr_rx_valid,
  output logic [15:0] nbr_rx_data,
  output logic [31:0] mot_freq,
  output logic [31:0] mot_cur,
  output logic [31:0] mot_temp,
  output logic [31:0] mot_err
);
  // fixed telemetry, distinct per motor so a swapped slice shows up
  assign mot_freq = 32'h0456_0123;
  assign mot_cur = 32'h0789_0ABC;
  assign mot_temp = 32'h2A1E_2B1F;
  assign mot_err = 32'h0800_0200;
  initial nbr_rx_data = 16'h0;
  // left drive fault and neighbour status are one-cycle pulses on request
  always @(posedge clk)
  begin
    mot_fault_in <= {1'b0, flt_go};
    nbr_rx_valid <= rx_go;
    // outside a pulse the data lines toggle, so stale data is never trusted
    nbr_rx_data <= rx_go ? RX_WORD : ~nbr_rx_data;
  end
endmodule

// >>> remote_io_ctrl_tb.sv
// self-checking bench for the remote I/O mode control block
`timescale 1ns/1ps
module remote_io_ctrl_tb;
  logic clk = 1'b0; // 25 MHz system clock
  logic rst_b = 1'b0; // synchronous reset, active low
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hready, hreadyout, hresp;
  logic [31:0] hrdata;
  logic nv_mode_in = 1'b0; // nonvolatile mode copy seen at start-up
  logic nv_mode, zone_auto_en, nbr_rx_valid, nbr_tx_valid, link_lost;
  logic [3:0] sens_in = 4'h0;
  logic [1:0] aux_out, motor_run, motor_brake, port_dig_mode, port_dig_out;
  logic [1:0] motor_fault, mot_fault_in;
  logic [31:0] motor_speed, mot_freq, mot_cur, mot_temp, mot_err;
  logic [15:0] motor_accel, nbr_rx_data, nbr_tx_data;
  logic [13:0] motor_decel;
  logic flt_go = 1'b0; // asks the drive model for a fault pulse
  logic rx_go = 1'b0; // asks the neighbour model for a status word
  int n_errors = 0;
  int tests_run = 0;
  int n_tx = 0; // neighbour transmit pulses seen
  logic [15:0] tx_seen = 16'h0;
  logic rd_dp = 1'b0; // a read data phase is in progress
  logic [31:0] exp_q[$]; // expected read data, oldest first
  logic [31:0] pl, pr, zv;

  always #20 clk = ~clk;
  assign hready = hreadyout; // the one slave drives the bus ready

  remote_io_ctrl #(.RESTART_CYCLES(20)) DUT (.clk(clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .nv_mode_in(nv_mode_in), .nv_mode(nv_mode), .zone_auto_en(zone_auto_en),
    .sens_in(sens_in), .aux_out(aux_out), .motor_run(motor_run),
    .motor_brake(motor_brake), .port_dig_mode(port_dig_mode),
    .port_dig_out(port_dig_out), .motor_speed(motor_speed), .motor_accel(motor_accel),
    .motor_decel(motor_decel), .motor_fault(motor_fault), .mot_fault_in(mot_fault_in),
    .mot_freq(mot_freq), .mot_cur(mot_cur), .mot_temp(mot_temp), .mot_err(mot_err),
    .nbr_rx_valid(nbr_rx_valid), .nbr_rx_data(nbr_rx_data),
    .nbr_tx_valid(nbr_tx_valid), .nbr_tx_data(nbr_tx_data), .link_lost(link_lost));

  nbr_model PART (.clk(clk), .flt_go(flt_go), .rx_go(rx_go), .mot_fault_in(mot_fault_in),
    .nbr_rx_valid(nbr_rx_valid), .nbr_rx_data(nbr_rx_data), .mot_freq(mot_freq),
    .mot_cur(mot_cur), .mot_temp(mot_temp), .mot_err(mot_err));

  // prints the counts and the verdict, then ends the run
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // one comparison, counted; case inequality so unknowns fail
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // single word transfer; holds each phase until ready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
  endtask

  // read: the expectation is queued, the monitor does the compare
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    xfer(1'b0, a, 32'h0);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // output monitor: read data at the data-phase edge, neighbour pulses
  always @(posedge clk)
  begin
    if (rd_dp && hreadyout === 1'b1 && exp_q.size() > 0)
    begin
      chk("hrdata", exp_q.pop_front(), hrdata);
      chk("hresp", 32'h0, 32'(hresp));
    end
    if (hreadyout === 1'b1)
      rd_dp <= hsel && htrans[1] && !hwrite;
    if (nbr_tx_valid === 1'b1)
    begin
      n_tx++;
      tx_seen <= nbr_tx_data;
    end
  end

  // main sequence: zone mode, entry, remote features, loss, re-entry
  initial
  begin
    void'($urandom(96511));
    cyc(16);
    rst_b <= 1'b1;
    sens_in <= 4'($urandom);
    cyc(3);
    chk("zone_auto_en", 32'h1, 32'(zone_auto_en));
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h0});
    rd(8'h40, 32'h0); // unmapped place reads zero
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h3);
    cyc(3);
    chk("motor_run", 32'h0, 32'(motor_run));
    xfer(1'b1, rio_pkg::OFS_CFG, 32'h1); // hold on loss, links kept
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h2});
    cyc(25);
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h1});
    chk("nv_mode", 32'h1, 32'(nv_mode));
    chk("zone_auto_en", 32'h0, 32'(zone_auto_en));
    xfer(1'b1, rio_pkg::OFS_TMO, 32'h0000_00C8);
    pl = $urandom;
    pr = $urandom;
    xfer(1'b1, rio_pkg::OFS_PAR_L, pl);
    xfer(1'b1, rio_pkg::OFS_PAR_R, pr);
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h3);
    cyc(3);
    chk("motor_run", 32'h3, 32'(motor_run));
    chk("motor_speed", {pr[15:0], pl[15:0]}, motor_speed);
    chk("motor_accel", 32'({pr[23:16], pl[23:16]}), 32'(motor_accel));
    chk("motor_decel", 32'({pr[30:24], pl[30:24]}), 32'(motor_decel));
    chk("motor_brake", 32'({pr[31], pl[31]}), 32'(motor_brake));
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h13B); // right port as digital output
    cyc(3);
    chk("motor_run", 32'h1, 32'(motor_run));
    chk("port_dig_mode", 32'h2, 32'(port_dig_mode));
    chk("port_dig_out", 32'h2, 32'(port_dig_out));
    chk("aux_out", 32'h1, 32'(aux_out));
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h43); // run with stop-all set
    cyc(3);
    chk("motor_run", 32'h0, 32'(motor_run));
    rd(rio_pkg::OFS_TEL_L0, {mot_cur[15:0], mot_freq[15:0]});
    rd(rio_pkg::OFS_TEL_R1, {mot_err[31:16], mot_temp[31:16]});
    rd(rio_pkg::OFS_TEL_L1, {mot_err[15:0], mot_temp[15:0]});
    rd(rio_pkg::OFS_TEL_R0, {mot_cur[31:16], mot_freq[31:16]});
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h3);
    flt_go <= 1'b1;
    @(posedge clk);
    flt_go <= 1'b0;
    cyc(3);
    chk("motor_fault", 32'h1, 32'(motor_fault));
    chk("motor_run", 32'h2, 32'(motor_run));
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h1003); // clear left fault, keep running
    cyc(4);
    chk("motor_fault", 32'h0, 32'(motor_fault));
    chk("motor_run", 32'h3, 32'(motor_run));
    zv = $urandom;
    xfer(1'b1, rio_pkg::OFS_ZONE, zv);
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    cyc(3);
    chk("nbr_tx_count", 32'h1, 32'(n_tx));
    chk("nbr_tx_data", 32'(zv[15:0]), 32'(tx_seen));
    rd(rio_pkg::OFS_ZONE, {16'hA5C3, zv[15:0]});
    cyc(250);
    chk("link_lost", 32'h1, 32'(link_lost));
    chk("motor_run", 32'h3, 32'(motor_run));
    chk("motor_speed", {pr[15:0], pl[15:0]}, motor_speed);
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h5});
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h0);
    cyc(3);
    chk("link_lost", 32'h0, 32'(link_lost));
    chk("motor_run", 32'h0, 32'(motor_run));
    // a plain reset must not leave remote mode
    nv_mode_in <= 1'b1;
    rst_b <= 1'b0;
    cyc(16);
    rst_b <= 1'b1;
    cyc(3);
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h1});
    xfer(1'b1, rio_pkg::OFS_KEY, rio_pkg::RECONF_KEY);
    cyc(2);
    rd(rio_pkg::OFS_STAT, {20'h0, sens_in, 8'h0});
    chk("nv_mode", 32'h0, 32'(nv_mode));
    xfer(1'b1, rio_pkg::OFS_CFG, 32'h7); // all-off on loss, links cleared
    cyc(25);
    xfer(1'b1, rio_pkg::OFS_TMO, 32'h0000_0064);
    xfer(1'b1, rio_pkg::OFS_CMD, 32'h103);
    cyc(3);
    chk("motor_run", 32'h3, 32'(motor_run));
    chk("aux_out", 32'h1, 32'(aux_out));
    xfer(1'b1, rio_pkg::OFS_ZONE, zv);
    // neighbour status offered while links are cleared must not be taken in
    rx_go <= 1'b1;
    @(posedge clk);
    rx_go <= 1'b0;
    cyc(4);
    chk("nbr_tx_count", 32'h1, 32'(n_tx));
    rd(rio_pkg::OFS_ZONE, {16'h0000, zv[15:0]});
    cyc(150);
    chk("link_lost", 32'h1, 32'(link_lost));
    chk("motor_run", 32'h0, 32'(motor_run));
    chk("aux_out", 32'h0, 32'(aux_out));
    stop_test();
  end

  // watchdog: the sequence needs well under 1500 cycles
  initial
  begin
    cyc(5000);
    n_errors++;
    stop_test();
  end
endmodule
